// ==== common/cmp_evt_pkg.sv ====
// constants and types for the comparator event, interrupt and status registers
package cmp_evt_pkg;

   // -------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // -------------------------------------------------------------
   localparam logic [7:0] IDX_EVT_CTRL    = 8'h02;
   localparam logic [7:0] IDX_IRQ_EN_CLR  = 8'h04;
   localparam logic [7:0] IDX_IRQ_EN_SET  = 8'h05;
   localparam logic [7:0] IDX_IRQ_FLAG    = 8'h06;
   localparam logic [7:0] IDX_LEVEL_STAT  = 8'h08;
   localparam logic [7:0] IDX_VALID_STAT  = 8'h09;
   localparam logic [7:0] IDX_COND_CTRL   = 8'h0D;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int unsigned EO_COMP_LSB    = 0;
   localparam int unsigned EO_WIN_BIT     = 4;
   localparam int unsigned EI_COMP_LSB    = 8;
   localparam int unsigned IRQ_WIN_BIT    = 4;
   localparam int unsigned WIN_POS_LSB    = 4;
   localparam int unsigned SYNC_BUSY_BIT  = 7;
   localparam int unsigned COND_COMP_LSB  = 0;
   localparam int unsigned COND_WIN_LSB   = 4;
   localparam int unsigned WIN_EN_BIT     = 6;

   // -------------------------------------------------------------
   // writable masks and reset values
   // -------------------------------------------------------------
   localparam logic [15:0] EVT_CTRL_MASK  = 16'h0313;
   localparam logic [7:0]  COND_MASK      = 8'h7F;
   localparam logic [15:0] EVT_CTRL_RST   = 16'h0000;
   localparam logic [7:0]  IRQ_EN_RST     = 8'h00;
   localparam logic [7:0]  IRQ_FLAG_RST   = 8'h00;
   localparam logic [7:0]  COND_RST       = 8'h00;

   // -------------------------------------------------------------
   // encodings
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      WPOS_ABOVE  = 2'h0,
      WPOS_INSIDE = 2'h1,
      WPOS_BELOW  = 2'h2
   } window_pos_t;

   typedef enum logic [1:0] {
      WCOND_ABOVE   = 2'h0,
      WCOND_INSIDE  = 2'h1,
      WCOND_BELOW   = 2'h2,
      WCOND_OUTSIDE = 2'h3
   } window_cond_t;

   typedef enum logic [1:0] {
      CCOND_TOGGLE = 2'h0,
      CCOND_RISE   = 2'h1,
      CCOND_FALL   = 2'h2,
      CCOND_DONE   = 2'h3
   } comp_cond_t;

   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b01,
      BUS_RDWAIT = 2'b10
   } bus_state_t;

endpackage

// ==== rtl/cmp_evt_regs.sv ====
// event, interrupt and status register bank of a two-channel comparator
`timescale 1ns/10ps

module cmp_evt_regs
   import cmp_evt_pkg::*;
#(
   parameter logic [1:0]  COMP_PRESENT   = 2'b11,
   parameter logic        WINDOW_PRESENT = 1'b1,
   parameter int unsigned EVT_SRC        = 2
) (
   // clock and reset
   input  wire logic               hclk,
   input  wire logic               hresetn,
   // ahb-lite slave
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic      [31:0]        hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   // comparator core, asynchronous to hclk
   input  wire logic [1:0]         comp_level,
   input  wire logic [1:0]         comp_ready,
   input  wire logic [1:0]         window_pos_in,
   input  wire logic               sync_busy_in,
   output logic      [1:0]         start_cmp,
   // event network, same clock
   input  wire logic [EVT_SRC-1:0] event_in,
   output logic      [1:0]         comp_event_out,
   output logic                    window_event_out,
   // interrupt
   output logic                    irq
);

   // -------------------------------------------------------------
   // input synchronisers
   // -------------------------------------------------------------
   // bit order: busy, window position, ready, level
   logic [6:0] sync1_q;
   logic [6:0] sync2_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= 7'h00;
         sync2_q <= 7'h00;
      end else begin
         sync1_q <= {sync_busy_in, window_pos_in, comp_ready, comp_level};
         sync2_q <= sync1_q;
      end
   end

   logic [1:0] lvl_s;
   logic [1:0] rdy_s;
   logic [1:0] wpos_s;
   logic       busy_s;
   assign lvl_s  = sync2_q[1:0];
   assign rdy_s  = sync2_q[3:2];
   assign wpos_s = sync2_q[5:4];
   assign busy_s = sync2_q[6];

   // -------------------------------------------------------------
   // bus front end
   // -------------------------------------------------------------
   bus_state_t  state_q;
   logic        wr_q;
   logic [7:0]  idx_q;
   logic [31:0] hrdata_q;
   logic        hreadyout_q;
   logic        hresp_q;
   logic        accept;
   logic        wr_en;
   logic [31:0] rd_data;

   assign accept = hsel & htrans[1] & hready;
   assign wr_en  = wr_q;

   // reads take one wait state so that a write just before is seen
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q     <= BUS_IDLE;
         wr_q        <= 1'b0;
         idx_q       <= 8'h00;
         hrdata_q    <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end else begin
         unique case (state_q)
            BUS_IDLE: begin
               wr_q <= accept & hwrite;
               if (accept) begin
                  idx_q <= haddr[9:2];
               end
               if (accept && !hwrite) begin
                  state_q     <= BUS_RDWAIT;
                  hreadyout_q <= 1'b0;
               end
            end
            BUS_RDWAIT: begin
               wr_q        <= 1'b0;
               hrdata_q    <= rd_data;
               hreadyout_q <= 1'b1;
               state_q     <= BUS_IDLE;
            end
         endcase
      end
   end

   assign hrdata    = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp     = hresp_q;

   // -------------------------------------------------------------
   // control registers
   // -------------------------------------------------------------
   logic [15:0] evt_ctrl_q;
   logic [7:0]  cond_q;
   logic [7:0]  irq_en_q;
   logic [7:0]  irq_impl;

   assign irq_impl = {3'b000, WINDOW_PRESENT, 2'b00, COMP_PRESENT};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_ctrl_q <= EVT_CTRL_RST;
         cond_q     <= COND_RST;
      end else if (wr_en) begin
         if (idx_q == IDX_EVT_CTRL) begin
            evt_ctrl_q <= hwdata[15:0] & EVT_CTRL_MASK;
         end
         if (idx_q == IDX_COND_CTRL) begin
            cond_q <= hwdata[7:0] & COND_MASK;
         end
      end
   end

   // one enable state behind both the set and the clear views
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_en_q <= IRQ_EN_RST;
      end else if (wr_en && idx_q == IDX_IRQ_EN_SET) begin
         irq_en_q <= irq_en_q | (hwdata[7:0] & irq_impl);
      end else if (wr_en && idx_q == IDX_IRQ_EN_CLR) begin
         irq_en_q <= irq_en_q & ~hwdata[7:0];
      end
   end

   // -------------------------------------------------------------
   // comparator channels
   // -------------------------------------------------------------
   logic [1:0] lvl_prev_q;
   logic [1:0] rdy_prev_q;
   logic [1:0] comp_set;
   logic [1:0] comp_tog;
   logic       any_evt;

   assign any_evt = |event_in;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lvl_prev_q <= 2'b00;
         rdy_prev_q <= 2'b00;
      end else begin
         lvl_prev_q <= lvl_s;
         rdy_prev_q <= rdy_s;
      end
   end

   for (genvar i = 0; i < 2; i++) begin : g_comp
      logic       rise;
      logic       fall;
      comp_cond_t cc;
      assign rise = rdy_s[i] & lvl_s[i] & ~lvl_prev_q[i];
      assign fall = rdy_s[i] & ~lvl_s[i] & lvl_prev_q[i];
      assign cc   = comp_cond_t'(cond_q[COND_COMP_LSB+2*i +: 2]);
      assign comp_tog[i] = COMP_PRESENT[i] & (rise | fall);
      always_comb begin
         unique case (cc)
            CCOND_TOGGLE: comp_set[i] = rise | fall;
            CCOND_RISE:   comp_set[i] = rise;
            CCOND_FALL:   comp_set[i] = fall;
            CCOND_DONE:   comp_set[i] = rdy_s[i] & ~rdy_prev_q[i];
         endcase
      end
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            start_cmp[i]      <= 1'b0;
            comp_event_out[i] <= 1'b0;
         end else begin
            start_cmp[i] <= COMP_PRESENT[i] & evt_ctrl_q[EI_COMP_LSB+i] & any_evt;
            comp_event_out[i] <= evt_ctrl_q[EO_COMP_LSB+i] & comp_tog[i];
         end
      end
   end

   // -------------------------------------------------------------
   // window function
   // -------------------------------------------------------------
   logic         win_en;
   logic [1:0]   win_pos;
   window_cond_t wc;
   logic         win_match;
   logic         win_match_q;
   logic         win_hit;

   assign win_en  = WINDOW_PRESENT & cond_q[WIN_EN_BIT];
   assign win_pos = win_en ? wpos_s : 2'h0;
   assign wc      = window_cond_t'(cond_q[COND_WIN_LSB +: 2]);

   always_comb begin
      unique case (wc)
         WCOND_ABOVE:   win_match = (win_pos == WPOS_ABOVE);
         WCOND_INSIDE:  win_match = (win_pos == WPOS_INSIDE);
         WCOND_BELOW:   win_match = (win_pos == WPOS_BELOW);
         WCOND_OUTSIDE: win_match = (win_pos != WPOS_INSIDE);
      endcase
   end

   // a flag is raised on entry into the chosen condition, not while it lasts
   assign win_hit = win_en & win_match & ~win_match_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_match_q      <= 1'b0;
         window_event_out <= 1'b0;
      end else begin
         win_match_q      <= win_en & win_match;
         window_event_out <= evt_ctrl_q[EO_WIN_BIT] & win_hit;
      end
   end

   // -------------------------------------------------------------
   // interrupt flags and request
   // -------------------------------------------------------------
   logic [7:0] irq_flag_q;
   logic [7:0] flag_set;
   logic [7:0] flag_clr;

   assign flag_set = {3'b000, win_hit, 2'b00, comp_set} & irq_impl;
   assign flag_clr = (wr_en && idx_q == IDX_IRQ_FLAG) ? hwdata[7:0] : 8'h00;

   // a new event wins over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_flag_q <= IRQ_FLAG_RST;
         irq        <= 1'b0;
      end else begin
         irq_flag_q <= (irq_flag_q & ~flag_clr) | flag_set;
         irq        <= |(irq_flag_q & irq_en_q);
      end
   end

   // -------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (idx_q)
         IDX_EVT_CTRL:   rd_data[15:0] = evt_ctrl_q;
         IDX_IRQ_EN_CLR: rd_data[7:0]  = irq_en_q;
         IDX_IRQ_EN_SET: rd_data[7:0]  = irq_en_q;
         IDX_IRQ_FLAG:   rd_data[7:0]  = irq_flag_q;
         IDX_LEVEL_STAT: rd_data[7:0]  = {2'b00, win_pos, 2'b00, lvl_s & COMP_PRESENT};
         IDX_VALID_STAT: rd_data[7:0]  = {busy_s, 5'b00000, rdy_s & COMP_PRESENT};
         IDX_COND_CTRL:  rd_data[7:0]  = cond_q;
         default:        rd_data       = 32'h0000_0000;
      endcase
   end

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   evt_start_a: assert property (
      (any_evt && evt_ctrl_q[EI_COMP_LSB] && COMP_PRESENT[0]) |=> start_cmp[0])
      else $error("event did not start comparator 0");

   evt_ignore_a: assert property (
      !evt_ctrl_q[EI_COMP_LSB+1] |=> !start_cmp[1])
      else $error("comparator 1 started with event input disabled");

   win_evt_gate_a: assert property (
      !evt_ctrl_q[EO_WIN_BIT] |=> !window_event_out)
      else $error("window event emitted while disabled");

   comp_evt_gate_a: assert property (
      !evt_ctrl_q[EO_COMP_LSB] |=> !comp_event_out[0])
      else $error("comparator 0 event emitted while disabled");

   en_set_a: assert property (
      (wr_en && idx_q == IDX_IRQ_EN_SET && hwdata[0] && COMP_PRESENT[0]) |=> irq_en_q[0])
      else $error("enable set write did not enable");

   en_clr_a: assert property (
      (wr_en && idx_q == IDX_IRQ_EN_CLR && hwdata[1]) |=> !irq_en_q[1])
      else $error("enable clear write did not disable");

   flag_clr_a: assert property (
      (wr_en && idx_q == IDX_IRQ_FLAG && hwdata[IRQ_WIN_BIT] && !flag_set[IRQ_WIN_BIT])
      |=> !irq_flag_q[IRQ_WIN_BIT])
      else $error("flag not cleared by write of one");

   irq_line_a: assert property (
      ((irq_flag_q & irq_en_q) != 8'h00) |=> irq)
      else $error("interrupt line low with enabled flag");

   reserved_zero_a: assert property (
      hrdata[31:16] == 16'h0000)
      else $error("reserved read bits not zero");

   win_pos_off_a: assert property (
      (state_q == BUS_RDWAIT && idx_q == IDX_LEVEL_STAT && !win_en)
      |=> hrdata[WIN_POS_LSB +: 2] == 2'h0)
      else $error("window position shown while window disabled");

   sync_busy_a: assert property (
      (state_q == BUS_RDWAIT && idx_q == IDX_VALID_STAT)
      |=> hrdata[SYNC_BUSY_BIT] == $past(busy_s))
      else $error("sync busy bit does not follow synchroniser");

   read_wait_a: assert property (
      (accept && !hwrite && state_q == BUS_IDLE) |=> !hreadyout ##1 hreadyout)
      else $error("read answer not after one wait state");

   comp1_evt_gate_a: assert property (
      !evt_ctrl_q[EO_COMP_LSB+1] |=> !comp_event_out[1])
      else $error("comparator 1 event emitted while disabled");

   no_evt_start_a: assert property (
      !any_evt |=> (start_cmp == 2'b00))
      else $error("comparison started with no incoming event");

   win_flag_set_a: assert property (
      win_hit |=> irq_flag_q[IRQ_WIN_BIT])
      else $error("window flag not set on its condition");

   comp_flag_set_a: assert property (
      (comp_set[1] && COMP_PRESENT[1]) |=> irq_flag_q[1])
      else $error("comparator 1 flag not set on its condition");

   absent_flag_a: assert property (
      (irq_flag_q & ~irq_impl) == 8'h00)
      else $error("flag set for an absent channel");

   irq_low_a: assert property (
      ((irq_flag_q & irq_en_q) == 8'h00) |=> !irq)
      else $error("interrupt line high with no enabled flag");

endmodule

// ==== tb/cmp_evt_regs_tb.sv ====
// self-checking bench for the comparator event, interrupt and status registers
`timescale 1ns/10ps

module cmp_evt_regs_tb;
   import cmp_evt_pkg::*;

   typedef struct packed {
      logic        w;
      logic [7:0]  idx;
      logic [31:0] d;
   } row_t;

   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, sync_busy_in;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, comp_level, comp_ready, window_pos_in, start_cmp;
   logic [1:0]  event_in, comp_event_out, lvl_set, win_set;
   logic        window_event_out;
   int          n_mismatch, cmp_count, cyc, ev0, ev1, wev;

   // -------------------------------------------------------------
   // ordinary register cases: write rows carry data, read rows expected value
   // -------------------------------------------------------------
   row_t rows[16] = '{
      '{1'b0, IDX_EVT_CTRL,   32'h0000_0000}, '{1'b0, IDX_IRQ_FLAG,   32'h0000_0000},
      '{1'b0, IDX_LEVEL_STAT, 32'h0000_0000}, '{1'b0, IDX_VALID_STAT, 32'h0000_0000},
      '{1'b1, IDX_EVT_CTRL,   32'h0000_FFFF}, '{1'b0, IDX_EVT_CTRL,   32'h0000_0313},
      '{1'b1, IDX_IRQ_EN_SET, 32'h0000_00FF}, '{1'b0, IDX_IRQ_EN_CLR, 32'h0000_0013},
      '{1'b1, IDX_IRQ_EN_CLR, 32'h0000_0001}, '{1'b0, IDX_IRQ_EN_SET, 32'h0000_0012},
      '{1'b1, IDX_IRQ_EN_CLR, 32'h0000_0000}, '{1'b0, IDX_IRQ_EN_CLR, 32'h0000_0012},
      '{1'b1, 8'h30,          32'hFFFF_FFFF}, '{1'b0, 8'h30,          32'h0000_0000},
      '{1'b1, IDX_COND_CTRL,  32'h0000_00FF}, '{1'b0, IDX_COND_CTRL,  32'h0000_007F}};

   cmp_evt_regs u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .comp_level(comp_level), .comp_ready(comp_ready), .window_pos_in(window_pos_in),
      .sync_busy_in(sync_busy_in), .start_cmp(start_cmp), .event_in(event_in),
      .comp_event_out(comp_event_out), .window_event_out(window_event_out), .irq(irq));

   core_model u_core (
      .hclk(hclk), .hresetn(hresetn), .start_cmp(start_cmp), .lvl_set(lvl_set),
      .win_set(win_set), .comp_level(comp_level), .comp_ready(comp_ready),
      .window_pos_in(window_pos_in), .sync_busy_in(sync_busy_in));

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   // outputs are settled at the falling edge, so pulses are counted there
   always @(negedge hclk) begin
      cyc++;
      ev0 += comp_event_out[0];
      ev1 += comp_event_out[1];
      wev += window_event_out;
      if (cyc == 6000) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask

   // hready is looked at just before the edge that samples it
   task automatic rdy();
      @(negedge hclk);
      while (hreadyout !== 1'b1) @(negedge hclk);
      rd = hrdata;
      @(posedge hclk);
   endtask

   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {22'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdy();
   endtask

   task automatic rchk(input string n, input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      chk(n, exp, rd);
   endtask

   task automatic pulse(input logic [1:0] ev, input logic [1:0] exp);
      @(posedge hclk);
      event_in <= ev;
      @(posedge hclk);
      event_in <= 2'h0;
      @(negedge hclk);
      chk("start_cmp", {30'h0, exp}, {30'h0, start_cmp});
   endtask

   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hwdata = 32'h0; event_in = 2'h0; lvl_set = 2'h0; win_set = 2'h0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      chk("irq reset", 32'h0, {31'h0, irq});
      foreach (rows[i]) begin
         if (rows[i].w)
            bus(1'b1, rows[i].idx, rows[i].d);
         else
            rchk("row read", rows[i].idx, rows[i].d);
      end
      // the condition row enabled the window while its event output was on
      chk("window event on", 32'h1, wev);
      bus(1'b1, IDX_EVT_CTRL, 32'h0);
      bus(1'b1, IDX_COND_CTRL, 32'h50);
      bus(1'b1, IDX_IRQ_EN_SET, 32'h13);
      pulse(2'h1, 2'h0);
      bus(1'b1, IDX_EVT_CTRL, 32'h0300);
      pulse(2'h2, 2'h3);
      repeat (4) @(posedge hclk);
      rchk("sync busy", IDX_VALID_STAT, 32'h80);
      repeat (20) @(posedge hclk);
      rchk("output valid", IDX_VALID_STAT, 32'h03);
      lvl_set <= 2'h3;
      win_set <= 2'h1;
      pulse(2'h1, 2'h3);
      repeat (30) @(posedge hclk);
      rchk("levels", IDX_LEVEL_STAT, 32'h13);
      rchk("flags set", IDX_IRQ_FLAG, 32'h13);
      @(negedge hclk);
      chk("irq on", 32'h1, {31'h0, irq});
      // only the window event seen after the rows so far
      chk("events off", 32'h1, ev0 + ev1 + wev);
      bus(1'b1, IDX_IRQ_EN_CLR, 32'h13);
      // irq follows the enables one edge later
      repeat (2) @(negedge hclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      bus(1'b1, IDX_IRQ_FLAG, 32'h12);
      rchk("flag clear", IDX_IRQ_FLAG, 32'h01);
      bus(1'b1, IDX_EVT_CTRL, 32'h0313);
      lvl_set <= 2'h0;
      win_set <= 2'h0;
      pulse(2'h1, 2'h3);
      repeat (30) @(posedge hclk);
      win_set <= 2'h1;
      repeat (10) @(posedge hclk);
      chk("comp0 event", 32'h1, ev0);
      chk("comp1 event", 32'h1, ev1);
      chk("window event", 32'h2, wev);
      for (int c = 0; c < 4; c++) begin
         win_set <= 2'h1;
         repeat (6) @(posedge hclk);
         bus(1'b1, IDX_COND_CTRL, {25'h0, 1'b1, c[1:0], 4'h0});
         bus(1'b1, IDX_IRQ_FLAG, 32'h10);
         win_set <= 2'h0;
         repeat (6) @(posedge hclk);
         bus(1'b0, IDX_IRQ_FLAG, 32'h0);
         chk("window cond", (c == 0 || c == 3) ? 32'h10 : 32'h0, rd & 32'h10);
      end
      // reset in mid-run while an enabled flag is pending
      bus(1'b1, IDX_IRQ_EN_SET, 32'h13);
      repeat (2) @(negedge hclk);
      chk("irq before reset", 32'h1, {31'h0, irq});
      @(posedge hclk);
      hresetn <= 1'b0;
      @(negedge hclk);
      chk("outputs in reset", 32'h2,
          {24'h0, comp_event_out, window_event_out, start_cmp, irq, hreadyout, hresp});
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rchk("flags after reset", IDX_IRQ_FLAG, 32'h0);
      rchk("enables after reset", IDX_IRQ_EN_SET, 32'h0);
      rchk("valid after reset", IDX_VALID_STAT, 32'h0);
      rchk("ctrl after reset", IDX_EVT_CTRL, 32'h0);
      pulse(2'h3, 2'h0);
      end_sim();
   end
endmodule

// ==== tb/core_model.sv ====
// behavioural comparator core: conversions started by start pulses
`timescale 1ns/10ps

module core_model #(
   parameter int CONV = 12
) (
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // from the register bank
   input  wire logic [1:0] start_cmp,
   // levels that the next conversion settles to, and the window position, passed straight through
   input  wire logic [1:0] lvl_set,
   input  wire logic [1:0] win_set,
   // to the register bank
   output logic      [1:0] comp_level,
   output logic      [1:0] comp_ready,
   output logic      [1:0] window_pos_in,
   output logic            sync_busy_in
);
   int         cnt;
   logic [1:0] act;

   assign window_pos_in = win_set;

   // starts that arrive during a conversion are dropped, as a busy core would
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt          <= 0;
         act          <= 2'h0;
         comp_level   <= 2'h0;
         comp_ready   <= 2'h0;
         sync_busy_in <= 1'b0;
      end else if (|start_cmp && cnt == 0) begin
         cnt          <= CONV;
         act          <= start_cmp;
         sync_busy_in <= 1'b1;
      end else if (cnt == 1) begin
         cnt          <= 0;
         sync_busy_in <= 1'b0;
         comp_level   <= (comp_level & ~act) | (lvl_set & act);
         comp_ready   <= comp_ready | act;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule
